// ### smc_params.svh
// Constants for the standby mode controller
`ifndef SMC_PARAMS_SVH
`define SMC_PARAMS_SVH

`define SMC_ADDR_W        8
`define SMC_OFF_MAIN_OSC  8'h00
`define SMC_OFF_PROC_CLK  8'h04
`define SMC_OFF_INT_OSC   8'h08
`define SMC_OFF_CLK_MODE  8'h0c
`define SMC_OFF_SEL       8'h10
`define SMC_OFF_STAT      8'h14
`define SMC_OFF_STATE     8'h18

`define SMC_BIT_MAIN_STOP  7
`define SMC_BIT_CPU_SOURCE 7
`define SMC_BIT_INT_STOP   0
`define SMC_BIT_PER_SELECT 0

`define SMC_FLD_SRC       1:0
`define SMC_FLD_SEL       2:0
`define SMC_FLD_STAT      4:0
`define SMC_FLD_STATE     3:0

`define SMC_SRC_HS        2'h0
`define SMC_SRC_INT       2'h1
`define SMC_SRC_SUB       2'h2

`define SMC_SEL_RST       3'h5
`define SMC_SEL_11        3'h1
`define SMC_SEL_13        3'h2
`define SMC_SEL_14        3'h3
`define SMC_SEL_15        3'h4
`define SMC_SEL_16        3'h5

`define SMC_INT_WAIT      5'h11
`define SMC_CNT_W         17
`define SMC_OPT_LOAD      2'h3

`endif

// ### smc_pkg.sv
// Types for the standby mode controller
`default_nettype none
package smc_pkg;

   typedef enum logic [1:0] {
      SMC_RUN  = 2'h0,
      SMC_HALT = 2'h1,
      SMC_STOP = 2'h3,
      SMC_WAIT = 2'h2
   } smc_state_e;

   typedef struct packed {
      logic       hs_en;
      logic       int_en;
      logic       cpu_en;
      logic       per_en;
      logic       per_sel;
      logic [1:0] cpu_src;
      logic       hold;
   } smc_clk_s;

endpackage
`default_nettype wire

// ### smc_standby.sv
// Standby controller: halt and stop modes with oscillation stabilization wait
// How it works
// - Halt gates CPU clock, oscillators keep running
// - Stop halts the high-speed oscillator
// - Interrupt leaves stop after stabilization wait
// - Interrupt leaves halt at once, no wait
// - Standby holds registers, memory and port states
// - Stop on internal clock keeps internal oscillator
// - Running internal oscillator not stopped in stop
// - Internal clock: CPU held 17 periods after stop
// - Internal stop bit acts only when option allows
// - After stop, CPU resumes on previous clock
// - After halt, CPU resumes on previous clock
// - Halt peripheral clock by select bit; stop stops it
// - Halt keeps high-speed oscillator unless stop bits set
// - Reset releases stop; wait counts only once the oscillator is ready
// - Three-bit select picks wait, resets to longest
`timescale 1ns/1ps
`default_nettype none
`include "smc_params.svh"

module smc_standby #(
   parameter int                  NUM_IRQ = 8,
   parameter logic [16:0]         CNT_11  = 17'h00800,
   parameter logic [16:0]         CNT_13  = 17'h02000,
   parameter logic [16:0]         CNT_14  = 17'h04000,
   parameter logic [16:0]         CNT_15  = 17'h08000,
   parameter logic [16:0]         CNT_16  = 17'h10000
) (
   input  wire logic                SYS_CLK,
   input  wire logic                RST,
   input  wire logic                PSEL,
   input  wire logic                PENABLE,
   input  wire logic                PWRITE,
   input  wire logic [7:0]          PADDR,
   input  wire logic [31:0]         PWDATA,
   output logic      [31:0]         PRDATA,
   output logic                     PREADY,
   output logic                     PSLVERR,
   input  wire logic                HALT_CMD,
   input  wire logic                STOP_CMD,
   input  wire logic [NUM_IRQ-1:0]  IRQ_FLAGS,
   input  wire logic [NUM_IRQ-1:0]  IRQ_MASK,
   input  wire logic                INT_OSC_TICK,
   input  wire logic                HS_OSC_READY,
   input  wire logic                OPT_INT_STOPPABLE,
   output logic                     HS_OSC_EN,
   output logic                     INT_OSC_EN,
   output logic                     CPU_CLK_EN,
   output logic [1:0]               CPU_CLK_SRC,
   output logic                     PER_CLK_EN,
   output logic                     PER_CLK_SEL,
   output logic                     STATE_HOLD,
   output logic                     IN_HALT,
   output logic                     IN_STOP,
   output logic                     WAKE
);

   // Pin synchronisers
   logic hs_rdy_m_r;
   logic hs_rdy_r;
   logic opt_m_r;
   logic opt_s_r;

   // Register file
   logic        main_osc_stop_r,     main_osc_stop_nxt;
   logic        cpu_clock_source_r,  cpu_clock_source_nxt;
   logic [1:0]  src_r,               src_nxt;
   logic        internal_osc_stop_r, internal_osc_stop_nxt;
   logic        per_clock_select_r,  per_clock_select_nxt;
   logic [2:0]  sel_r,               sel_nxt;
   logic        opt_r,               opt_nxt;
   logic [1:0]  opt_ld_r,            opt_ld_nxt;

   // APB answer
   logic [31:0] rdata_r,  rdata_nxt;
   logic        ready_r,  ready_nxt;
   logic        err_r,    err_nxt;

   // Sequencer
   smc_pkg::smc_state_e st_r, st_nxt;
   logic [1:0]  saved_r,  saved_nxt;
   logic [16:0] ost_r,    ost_nxt;
   logic [4:0]  tick_r,   tick_nxt;
   logic        wake_r,   wake_nxt;
   logic        halt_r,   halt_nxt;
   smc_pkg::smc_clk_s   clk_r, clk_nxt;

   logic        wake_req;
   logic        acc;
   logic        wr;
   logic [16:0] target;
   logic [4:0]  stab_status;
   logic        hs_on;
   logic        int_on;

   assign wake_req = |(IRQ_FLAGS & ~IRQ_MASK);
   assign acc      = PSEL & PENABLE & ~ready_r;
   assign wr       = PSEL & PENABLE & ready_r & PWRITE;
   assign hs_on    = ~(main_osc_stop_r | cpu_clock_source_r);
   assign int_on   = ~(opt_r & internal_osc_stop_r);

   // Wait length from the select field
   always_comb begin
      case (sel_r)
         `SMC_SEL_11: target = CNT_11;
         `SMC_SEL_13: target = CNT_13;
         `SMC_SEL_14: target = CNT_14;
         `SMC_SEL_15: target = CNT_15;
         default:     target = CNT_16;
      endcase
   end

   // Elapsed-time status bits
   assign stab_status = {ost_r >= CNT_11, ost_r >= CNT_13, ost_r >= CNT_14,
                         ost_r >= CNT_15, ost_r >= CNT_16};

   // Synchronisers
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         hs_rdy_m_r <= 1'b0;
         hs_rdy_r   <= 1'b0;
         opt_m_r    <= 1'b0;
         opt_s_r    <= 1'b0;
      end else begin
         hs_rdy_m_r <= HS_OSC_READY;
         hs_rdy_r   <= hs_rdy_m_r;
         opt_m_r    <= OPT_INT_STOPPABLE;
         opt_s_r    <= opt_m_r;
      end
   end

   // Register writes and option capture
   always_comb begin
      main_osc_stop_nxt     = main_osc_stop_r;
      cpu_clock_source_nxt  = cpu_clock_source_r;
      src_nxt               = src_r;
      internal_osc_stop_nxt = internal_osc_stop_r;
      per_clock_select_nxt  = per_clock_select_r;
      sel_nxt               = sel_r;
      opt_nxt               = opt_r;
      opt_ld_nxt            = opt_ld_r;
      // Strap taken at third edge after reset
      if (opt_ld_r != `SMC_OPT_LOAD) begin
         opt_nxt    = opt_s_r;
         opt_ld_nxt = opt_ld_r + 2'h1;
      end
      if (wr) begin
         case (PADDR)
            `SMC_OFF_MAIN_OSC: main_osc_stop_nxt = PWDATA[`SMC_BIT_MAIN_STOP];
            `SMC_OFF_PROC_CLK: begin
               cpu_clock_source_nxt = PWDATA[`SMC_BIT_CPU_SOURCE];
               src_nxt              = PWDATA[`SMC_FLD_SRC];
            end
            `SMC_OFF_INT_OSC:  internal_osc_stop_nxt = PWDATA[`SMC_BIT_INT_STOP];
            `SMC_OFF_CLK_MODE: per_clock_select_nxt  = PWDATA[`SMC_BIT_PER_SELECT];
            `SMC_OFF_SEL:      sel_nxt               = PWDATA[`SMC_FLD_SEL];
            default:           sel_nxt               = sel_r;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         main_osc_stop_r     <= 1'b0;
         cpu_clock_source_r  <= 1'b0;
         src_r               <= `SMC_SRC_INT;
         internal_osc_stop_r <= 1'b0;
         per_clock_select_r  <= 1'b0;
         sel_r               <= `SMC_SEL_RST;
         opt_r               <= 1'b0;
         opt_ld_r            <= 2'h0;
      end else begin
         main_osc_stop_r     <= main_osc_stop_nxt;
         cpu_clock_source_r  <= cpu_clock_source_nxt;
         src_r               <= src_nxt;
         internal_osc_stop_r <= internal_osc_stop_nxt;
         per_clock_select_r  <= per_clock_select_nxt;
         sel_r               <= sel_nxt;
         opt_r               <= opt_nxt;
         opt_ld_r            <= opt_ld_nxt;
      end
   end

   // APB read path, one wait state
   always_comb begin
      rdata_nxt = rdata_r;
      ready_nxt = 1'b0;
      err_nxt   = 1'b0;
      if (acc) begin
         ready_nxt = 1'b1;
         rdata_nxt = 32'h0;
         case (PADDR)
            `SMC_OFF_MAIN_OSC: rdata_nxt[`SMC_BIT_MAIN_STOP] = main_osc_stop_r;
            `SMC_OFF_PROC_CLK: begin
               rdata_nxt[`SMC_BIT_CPU_SOURCE] = cpu_clock_source_r;
               rdata_nxt[`SMC_FLD_SRC]        = src_r;
            end
            `SMC_OFF_INT_OSC:  rdata_nxt[`SMC_BIT_INT_STOP]   = internal_osc_stop_r;
            `SMC_OFF_CLK_MODE: rdata_nxt[`SMC_BIT_PER_SELECT] = per_clock_select_r;
            `SMC_OFF_SEL:      rdata_nxt[`SMC_FLD_SEL]        = sel_r;
            `SMC_OFF_STAT:     rdata_nxt[`SMC_FLD_STAT]       = stab_status;
            `SMC_OFF_STATE:    rdata_nxt[`SMC_FLD_STATE]      = {opt_r, saved_r == `SMC_SRC_SUB, st_r};
            default:           err_nxt = 1'b1;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         rdata_r <= 32'h0;
         ready_r <= 1'b0;
         err_r   <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         ready_r <= ready_nxt;
         err_r   <= err_nxt;
      end
   end

   // Standby sequencer
   always_comb begin
      st_nxt    = st_r;
      saved_nxt = saved_r;
      ost_nxt   = ost_r;
      tick_nxt  = tick_r;
      wake_nxt  = 1'b0;
      // Stabilization counter advances only while oscillating
      if (clk_r.hs_en && hs_rdy_r && ost_r < target) begin
         ost_nxt = ost_r + 17'h1;
      end
      if (!hs_on && st_r == smc_pkg::SMC_RUN) begin
         ost_nxt = 17'h0;
      end
      case (st_r)
         smc_pkg::SMC_RUN: begin
            if (STOP_CMD && src_r != `SMC_SRC_SUB) begin
               st_nxt    = smc_pkg::SMC_STOP;
               saved_nxt = src_r;
               ost_nxt   = 17'h0;
            end else if (HALT_CMD) begin
               st_nxt    = smc_pkg::SMC_HALT;
               saved_nxt = src_r;
            end
         end
         smc_pkg::SMC_HALT: begin
            if (wake_req) begin
               st_nxt   = smc_pkg::SMC_RUN;
               wake_nxt = 1'b1;
            end
         end
         smc_pkg::SMC_STOP: begin
            ost_nxt = 17'h0;
            if (wake_req) begin
               st_nxt   = smc_pkg::SMC_WAIT;
               tick_nxt = 5'h0;
            end
         end
         smc_pkg::SMC_WAIT: begin
            if (saved_r == `SMC_SRC_INT) begin
               if (INT_OSC_TICK) begin
                  tick_nxt = tick_r + 5'h1;
               end
               if (tick_r == `SMC_INT_WAIT) begin
                  st_nxt   = smc_pkg::SMC_RUN;
                  wake_nxt = 1'b1;
               end
            end else if (ost_r >= target) begin
               st_nxt   = smc_pkg::SMC_RUN;
               wake_nxt = 1'b1;
            end
         end
         default: st_nxt = smc_pkg::SMC_RUN;
      endcase
   end

   // Clock controls per state
   always_comb begin
      halt_nxt        = st_nxt == smc_pkg::SMC_HALT;
      clk_nxt.hs_en   = hs_on;
      clk_nxt.int_en  = int_on;
      clk_nxt.cpu_en  = 1'b1;
      clk_nxt.per_en  = 1'b1;
      clk_nxt.per_sel = per_clock_select_r;
      clk_nxt.cpu_src = src_r;
      clk_nxt.hold    = 1'b0;
      case (st_nxt)
         smc_pkg::SMC_HALT: begin
            clk_nxt.cpu_en  = 1'b0;
            clk_nxt.cpu_src = saved_nxt;
            clk_nxt.hold    = 1'b1;
         end
         smc_pkg::SMC_STOP: begin
            clk_nxt.hs_en   = 1'b0;
            clk_nxt.cpu_en  = 1'b0;
            clk_nxt.per_en  = 1'b0;
            clk_nxt.cpu_src = saved_nxt;
            clk_nxt.hold    = 1'b1;
         end
         smc_pkg::SMC_WAIT: begin
            clk_nxt.hs_en   = 1'b1;
            clk_nxt.cpu_en  = 1'b0;
            clk_nxt.per_en  = 1'b0;
            clk_nxt.cpu_src = saved_nxt;
            clk_nxt.hold    = 1'b1;
         end
         default: clk_nxt.cpu_en = 1'b1;
      endcase
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         st_r    <= smc_pkg::SMC_RUN;
         saved_r <= `SMC_SRC_INT;
         ost_r   <= 17'h0;
         tick_r  <= 5'h0;
         wake_r  <= 1'b0;
         halt_r  <= 1'b0;
         clk_r   <= '{hs_en: 1'b1, int_en: 1'b1, cpu_en: 1'b1, per_en: 1'b1,
                      per_sel: 1'b0, cpu_src: `SMC_SRC_INT, hold: 1'b0};
      end else begin
         st_r    <= st_nxt;
         saved_r <= saved_nxt;
         ost_r   <= ost_nxt;
         tick_r  <= tick_nxt;
         wake_r  <= wake_nxt;
         halt_r  <= halt_nxt;
         clk_r   <= clk_nxt;
      end
   end

   // Outputs straight from flops
   assign PRDATA      = rdata_r;
   assign PREADY      = ready_r;
   assign PSLVERR     = err_r;
   assign HS_OSC_EN   = clk_r.hs_en;
   assign INT_OSC_EN  = clk_r.int_en;
   assign CPU_CLK_EN  = clk_r.cpu_en;
   assign CPU_CLK_SRC = clk_r.cpu_src;
   assign PER_CLK_EN  = clk_r.per_en;
   assign PER_CLK_SEL = clk_r.per_sel;
   assign STATE_HOLD  = clk_r.hold;
   assign IN_HALT     = halt_r;
   assign IN_STOP     = st_r[1];
   assign WAKE        = wake_r;

endmodule

`default_nettype wire

// ### smc_cpu_model.sv
// CPU core model issuing halt and stop instructions
`timescale 1ns/1ps
`default_nettype none
module smc_cpu_model (
   input  wire logic       clk,
   input  wire logic       cpu_clk_en,
   input  wire logic [1:0] src,
   input  wire logic       do_halt,
   input  wire logic       do_stop,
   output logic            halt_cmd,
   output logic            stop_cmd
);
   // Instructions run only on a live CPU clock
   always_ff @(posedge clk) begin
      halt_cmd <= do_halt && cpu_clk_en;
      stop_cmd <= do_stop && cpu_clk_en && src != 2'h2;
   end
endmodule
`default_nettype wire

// ### smc_standby_sva.sv
// Assertions for the standby controller
`timescale 1ns/1ps
`default_nettype none
module smc_standby_sva #(
   parameter int NUM_IRQ = 8
) (
   input wire logic               SYS_CLK,
   input wire logic               RST,
   input wire logic               HALT_CMD,
   input wire logic               STOP_CMD,
   input wire logic [NUM_IRQ-1:0] IRQ_FLAGS,
   input wire logic [NUM_IRQ-1:0] IRQ_MASK,
   input wire logic               HS_OSC_EN,
   input wire logic               INT_OSC_EN,
   input wire logic               CPU_CLK_EN,
   input wire logic [1:0]         CPU_CLK_SRC,
   input wire logic               PER_CLK_EN,
   input wire logic               STATE_HOLD,
   input wire logic               IN_HALT,
   input wire logic               IN_STOP,
   input wire logic               WAKE
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   logic       unm, stp, woke_r, woke_nxt;
   logic [7:0] wcnt_r, wcnt_nxt;
   assign unm = |(IRQ_FLAGS & ~IRQ_MASK);
   assign stp = STOP_CMD && !STATE_HOLD && CPU_CLK_SRC != 2'h2;
   // Cycles since a wake request in stop
   always_comb begin
      woke_nxt = IN_STOP && (woke_r || unm);
      wcnt_nxt = woke_r ? wcnt_r + 8'h01 : 8'h00;
   end
   always_ff @(posedge SYS_CLK) begin
      woke_r <= RST ? 1'b0 : woke_nxt;
      wcnt_r <= RST ? 8'h00 : wcnt_nxt;
   end
   a_halt_gates_cpu: assert property (HALT_CMD && !STOP_CMD && !STATE_HOLD |=> !CPU_CLK_EN && IN_HALT)
      else $error("halt gate");
   a_halt_osc_run: assert property (HALT_CMD && !STOP_CMD && !STATE_HOLD |=> $stable({INT_OSC_EN, HS_OSC_EN}))
      else $error("halt osc");
   a_stop_osc_off: assert property (stp |=> IN_STOP && !HS_OSC_EN && !PER_CLK_EN && !CPU_CLK_EN)
      else $error("stop osc");
   a_stop_int_kept: assert property (stp && INT_OSC_EN |=> INT_OSC_EN)
      else $error("stop int osc");
   a_halt_wake_now: assert property (IN_HALT && !CPU_CLK_EN && unm |=> CPU_CLK_EN && WAKE)
      else $error("halt wake");
   a_masked_sleep: assert property (IN_HALT && !unm |=> !CPU_CLK_EN)
      else $error("masked wake");
   a_stop_wait_min: assert property (WAKE && woke_r |-> wcnt_r >= 8'h04)
      else $error("stop wait short");
   a_wake_pulse: assert property (WAKE |-> CPU_CLK_EN ##1 !WAKE)
      else $error("wake pulse");
   a_gated_holds: assert property (!CPU_CLK_EN |-> STATE_HOLD)
      else $error("hold");
   a_src_kept: assert property (STATE_HOLD |=> $stable(CPU_CLK_SRC))
      else $error("src");
   c_halt_wake: cover property (IN_HALT && unm ##1 WAKE);
   c_stop_wake: cover property (WAKE && woke_r);
   c_masked: cover property (IN_HALT && |IRQ_FLAGS && !unm);
endmodule
bind smc_standby smc_standby_sva #(.NUM_IRQ(NUM_IRQ)) smc_standby_sva_i (.SYS_CLK, .RST, .HALT_CMD, .STOP_CMD,
   .IRQ_FLAGS, .IRQ_MASK, .HS_OSC_EN, .INT_OSC_EN, .CPU_CLK_EN, .CPU_CLK_SRC, .PER_CLK_EN, .STATE_HOLD,
   .IN_HALT, .IN_STOP, .WAKE);
`default_nettype wire

// ### smc_standby_tb.sv
// Testbench for the standby controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; $display("ERROR t=%0t %h %h", $time, a, e); end end
module smc_standby_tb;
   logic        SYS_CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, HALT_CMD, STOP_CMD, INT_OSC_TICK;
   logic        HS_OSC_READY, OPT_INT_STOPPABLE, HS_OSC_EN, INT_OSC_EN, CPU_CLK_EN, PER_CLK_EN, PER_CLK_SEL;
   logic        STATE_HOLD, IN_HALT, IN_STOP, WAKE, do_halt, do_stop, err;
   logic [1:0]  CPU_CLK_SRC;
   logic [7:0]  PADDR, IRQ_FLAGS, IRQ_MASK;
   logic [31:0] PWDATA, PRDATA, rd;
   int          miscompares, cmp_count, n;
   // Address, reset value, error
   logic [40:0] rows [8] = '{{8'h00, 32'h0, 1'b0}, {8'h04, 32'h1, 1'b0}, {8'h08, 32'h0, 1'b0},
                             {8'h0c, 32'h0, 1'b0}, {8'h10, 32'h5, 1'b0}, {8'h1c, 32'h0, 1'b1},
                             {8'h14, 32'h1f, 1'b0}, {8'h18, 32'h0, 1'b0}};
   smc_standby #(.CNT_11(17'h4), .CNT_13(17'h8), .CNT_14(17'hc), .CNT_15(17'h10), .CNT_16(17'h14)) smc_standby_i (
      .SYS_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .HALT_CMD,
      .STOP_CMD, .IRQ_FLAGS, .IRQ_MASK, .INT_OSC_TICK, .HS_OSC_READY, .OPT_INT_STOPPABLE, .HS_OSC_EN,
      .INT_OSC_EN, .CPU_CLK_EN, .CPU_CLK_SRC, .PER_CLK_EN, .PER_CLK_SEL, .STATE_HOLD, .IN_HALT, .IN_STOP, .WAKE);
   smc_cpu_model smc_cpu_model_i (.clk(SYS_CLK), .cpu_clk_en(CPU_CLK_EN), .src(CPU_CLK_SRC), .do_halt, .do_stop,
      .halt_cmd(HALT_CMD), .stop_cmd(STOP_CMD));
   initial begin
      SYS_CLK = 1'b0;
      forever #5 SYS_CLK = ~SYS_CLK;
   end
   // Oscillator models
   always @(posedge SYS_CLK) begin
      HS_OSC_READY <= HS_OSC_EN;
      INT_OSC_TICK <= !INT_OSC_TICK && INT_OSC_EN;
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge SYS_CLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge SYS_CLK);
         k++;
      end while (PREADY !== 1'b1 && k < 20);
      if (k == 20) miscompares++;
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge SYS_CLK);
   endtask
   task automatic wait_run();
      n = 0;
      do begin
         @(posedge SYS_CLK);
         n++;
      end while (CPU_CLK_EN !== 1'b1 && n < 2000);
   endtask
   task automatic cmd(input logic stop);
      do_halt <= !stop;
      do_stop <= stop;
      @(posedge SYS_CLK);
      do_halt <= 1'b0;
      do_stop <= 1'b0;
      repeat (4) @(posedge SYS_CLK);
   endtask
   task automatic reset(input int c);
      RST <= 1'b1;
      repeat (c) @(posedge SYS_CLK);
      RST <= 1'b0;
      @(posedge SYS_CLK);
   endtask
   task automatic results();
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      {PSEL, PENABLE, PWRITE, do_halt, do_stop, INT_OSC_TICK, HS_OSC_READY, OPT_INT_STOPPABLE} = 8'h00;
      RST = 1'b1;
      PADDR = 8'h00;
      PWDATA = 32'h0;
      IRQ_FLAGS = 8'h00;
      IRQ_MASK = 8'h00;
      miscompares = 0;
      cmp_count = 0;
      reset(20);
      foreach (rows[i]) begin
         apb(1'b0, rows[i][40:33], 32'h0);
         `CHK({rd, err}, rows[i][32:0])
      end
      apb(1'b1, 8'h08, 32'h1);
      repeat (2) @(posedge SYS_CLK);
      `CHK(INT_OSC_EN, 1'b1)
      apb(1'b1, 8'h08, 32'h0);
      // Halt, masked then unmasked request
      IRQ_FLAGS <= 8'h01;
      IRQ_MASK <= 8'h01;
      cmd(1'b0);
      `CHK({CPU_CLK_EN, IN_HALT, STATE_HOLD, INT_OSC_EN, HS_OSC_EN}, 5'h0f)
      IRQ_MASK <= 8'h00;
      wait_run();
      `CHK({n, WAKE, CPU_CLK_SRC}, {32'h2, 1'b1, 2'h1})
      IRQ_FLAGS <= 8'h00;
      // Halt on subsystem clock keeps that source
      apb(1'b1, 8'h04, 32'h2);
      cmd(1'b0);
      apb(1'b0, 8'h18, 32'h0);
      `CHK({rd, err, CPU_CLK_SRC}, {32'h5, 1'b0, 2'h2})
      IRQ_FLAGS <= 8'h04;
      wait_run();
      `CHK({n, CPU_CLK_SRC, IN_HALT}, {32'h2, 2'h2, 1'b0})
      IRQ_FLAGS <= 8'h00;
      // Halt with main oscillator stopped, peripherals on high-speed clock
      apb(1'b1, 8'h00, 32'h80);
      apb(1'b1, 8'h0c, 32'h1);
      cmd(1'b0);
      `CHK({HS_OSC_EN, INT_OSC_EN, PER_CLK_EN, PER_CLK_SEL}, 4'h7)
      IRQ_FLAGS <= 8'h02;
      wait_run();
      IRQ_FLAGS <= 8'h00;
      apb(1'b1, 8'h00, 32'h0);
      // Stop on high-speed clock, every wait selection
      apb(1'b1, 8'h04, 32'h0);
      for (int s = 1; s <= 5; s++) begin
         apb(1'b1, 8'h10, 32'(s));
         cmd(1'b1);
         `CHK({HS_OSC_EN, INT_OSC_EN, PER_CLK_EN, IN_STOP, CPU_CLK_EN}, 5'h0a)
         IRQ_FLAGS <= 8'h80;
         wait_run();
         `CHK(n >= 4 * s + 3 && n <= 4 * s + 12, 1'b1)
         `CHK(CPU_CLK_SRC, 2'h0)
         IRQ_FLAGS <= 8'h00;
      end
      // Stop on internal clock
      apb(1'b1, 8'h04, 32'h1);
      cmd(1'b1);
      IRQ_FLAGS <= 8'h80;
      wait_run();
      `CHK(n >= 32 && n <= 40, 1'b1)
      `CHK({CPU_CLK_SRC, INT_OSC_EN}, 3'h3)
      IRQ_FLAGS <= 8'h00;
      // Reset during stop, then stoppable internal oscillator
      cmd(1'b1);
      OPT_INT_STOPPABLE <= 1'b1;
      reset(3);
      `CHK({CPU_CLK_EN, IN_STOP}, 2'h2)
      repeat (4) @(posedge SYS_CLK);
      apb(1'b1, 8'h08, 32'h1);
      repeat (2) @(posedge SYS_CLK);
      `CHK(INT_OSC_EN, 1'b0)
      results();
   end
   initial begin
      #200000;
      miscompares++;
      results();
   end
endmodule
`default_nettype wire
